// ===== verilog/fcs_pkg.sv
// Constants for the FIFO configuration capture and status flag block.
// Assumes a single 200 MHz system clock that samples every pin.
package fcs_pkg;
  // ****************************************
  // Sizes
  // ****************************************
  localparam int DW = 36;
  localparam int AW = 10;
  localparam int PTR_W = 11;
  localparam int OFS_W = 10;
  localparam logic [11:0] DEPTH_CNT = 12'h400;
  localparam int SYNC_STAGES = 3;
  localparam real CLK_PERIOD_NS = 5.0;

  // ****************************************
  // Bus width codes
  // ****************************************
  localparam logic [1:0] W36 = 2'h0;
  localparam logic [1:0] W18 = 2'h1;
  localparam logic [1:0] W9 = 2'h2;

  // ****************************************
  // Positions in the sampled pin vector
  // ****************************************
  localparam int P_RDHSTL = 0;
  localparam int P_SYSHSTL = 1;
  localparam int P_OFFSET_DEFAULT_SEL0 = 2;
  localparam int P_OFFSET_DEFAULT_SEL1 = 3;
  localparam int P_BM = 4;
  localparam int P_IW = 5;
  localparam int P_OW = 6;
  localparam int P_BYTEORD = 7;
  localparam int P_FTIME = 8;
  localparam int P_PARITY = 9;
  localparam int P_FALL_THROUGH_MODE = 10;
  localparam int P_LOAD = 11;
  localparam int P_MRS = 12;
  localparam int P_PRS = 13;
  localparam int P_WCLK = 14;
  localparam int P_WEN = 15;
  localparam int P_RCLK = 16;
  localparam int P_REN = 17;
  localparam int P_MARK = 18;
  localparam int P_SCLK = 19;
  localparam int P_SEN = 20;
  localparam int P_SIN = 21;
  localparam int P_DATA = 22;
  localparam int PIN_W = 58;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [PIN_W-1:0] PIN_RESET = '0;
  localparam logic [1:0] SEG_RESET = 2'h0;

  // ****************************************
  // Default offsets, index {load, sel1, sel0}
  // ****************************************
  function automatic logic [OFS_W-1:0] def_offset(input logic [2:0] sel);
    logic [OFS_W-1:0] v;
    v = 10'h007;
    case (sel)
      3'h0: v = 10'h007;
      3'h1: v = 10'h00f;
      3'h2: v = 10'h01f;
      3'h3: v = 10'h03f;
      3'h4: v = 10'h07f;
      3'h5: v = 10'h0ff;
      3'h6: v = 10'h1ff;
      default: v = 10'h003;
    endcase
    return v;
  endfunction
endpackage

// ===== verilog/fcs_flags_top.sv
// Configuration straps, offset registers, bus matching and status flags of a dual-port FIFO.
// Assumes write, read and serial clocks are pins sampled by sys_clk, well below its rate.
// Behaviour
// - Read-port select low at reset: no echoes
// - Load and selects pick offset, method
// - Load low accesses offsets, chosen method only
// - Offsets read back in parallel only
// - Width selects latched; flags count words
// - Big-endian: most significant part out first
// - Little-endian: least significant part out first
// - Async flag timing: set/clear on opposite clocks
// - Sync flag timing: own clock only
// - Parity on: D8, D17, D26, D35 parity
// - Parity off: D8, D17 valid, D32-35 ignored
// - Standard full low at depth, blocks writes
// - Fall-through ready counts output register word
// - Full flag two write-clock register stages
// - Retransmit: full compares with mark
// - Standard empty low when empty, blocks reads
// - Output ready low with first valid word
// - Output ready high only on true read
// - Empty two stages, ready three stages
// - Full clears two write clocks after read
// - Writes ignored while full
// - First word falls through on third edge
//
`timescale 1ns/10ps
module fcs_flags_top (
  input wire logic sys_clk, // System clock
  input wire logic resetn, // Async reset, active low
  input wire logic masterResetN, // Master reset pin
  input wire logic partialResetN, // Partial reset pin
  input wire logic readPortSignalSel, // Read port level strap
  input wire logic systemSignalSel, // System level strap
  input wire logic offsetLoadN, // Offset load pin
  input wire logic offsetDefaultSel0, // Default offset select
  input wire logic offsetDefaultSel1, // Default offset select
  input wire logic widthMatchEnable, // Bus matching strap
  input wire logic inputWidthSel, // Input width strap
  input wire logic outputWidthSel, // Output width strap
  input wire logic byteOrderSelN, // Low: big-endian
  input wire logic flagTimingSel, // High: synchronous almost flags
  input wire logic parityPlacementSel, // High: interspersed parity
  input wire logic fallThroughMode, // High: fall-through timing
  input wire logic writeClk, // Write clock pin
  input wire logic writeEnN, // Write enable
  input wire logic [35:0] dataIn, // Write data
  input wire logic readClk, // Read clock pin
  input wire logic readEnN, // Read enable
  input wire logic markN, // Retransmit mark
  input wire logic serialClk, // Serial offset clock
  input wire logic serialEnN, // Serial offset enable
  input wire logic serialIn, // Serial offset data
  output logic [35:0] dataOut, // Read data
  output logic fullN, // Full or input ready
  output logic emptyN, // Empty or output ready
  output logic almostEmptyN, // Almost empty
  output logic almostFullN, // Almost full
  output logic echoedReadClk, // Echo of read clock
  output logic echoedReadEnN, // Echo of read enable
  output logic readPortHstl, // Captured read port level
  output logic systemHstl // Captured system level
);
  // ****************************************
  // Pin sampling
  // ****************************************
  logic [fcs_pkg::PIN_W-1:0] pinRaw, pinS1_q, pinS2_q, pinS3_q, pinF_q, pinP_q, pinF_d;
  assign pinRaw = {dataIn, serialIn, serialEnN, serialClk, markN, readEnN, readClk, writeEnN, writeClk,
                   partialResetN, masterResetN, offsetLoadN, fallThroughMode, parityPlacementSel,
                   flagTimingSel, byteOrderSelN, outputWidthSel, inputWidthSel, widthMatchEnable,
                   offsetDefaultSel1, offsetDefaultSel0, systemSignalSel, readPortSignalSel};
  assign pinF_d = (~(pinS2_q ^ pinS3_q) & pinS3_q) | ((pinS2_q ^ pinS3_q) & pinF_q);

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      pinS1_q <= fcs_pkg::PIN_RESET;
      pinS2_q <= fcs_pkg::PIN_RESET;
      pinS3_q <= fcs_pkg::PIN_RESET;
      pinF_q <= fcs_pkg::PIN_RESET;
      pinP_q <= fcs_pkg::PIN_RESET;
    end
    else
    begin
      pinS1_q <= pinRaw;
      pinS2_q <= pinS1_q;
      pinS3_q <= pinS2_q;
      pinF_q <= pinF_d;
      pinP_q <= pinF_q;
    end
  end

  logic mrsAct, prsAct, ldHigh, wRise, rRise, sRise;
  logic [35:0] dIn;
  assign mrsAct = ~pinF_q[fcs_pkg::P_MRS];
  assign prsAct = ~pinF_q[fcs_pkg::P_PRS];
  assign ldHigh = pinF_q[fcs_pkg::P_LOAD];
  assign wRise = pinF_q[fcs_pkg::P_WCLK] & ~pinP_q[fcs_pkg::P_WCLK];
  assign rRise = pinF_q[fcs_pkg::P_RCLK] & ~pinP_q[fcs_pkg::P_RCLK];
  assign sRise = pinF_q[fcs_pkg::P_SCLK] & ~pinP_q[fcs_pkg::P_SCLK];
  assign dIn = pinF_q[fcs_pkg::P_DATA +: fcs_pkg::DW];

  // ****************************************
  // Configuration capture
  // ****************************************
  logic cfgEcho_q, cfgSys_q, cfgParallel_q, cfgBig_q, cfgSyncFlags_q, cfgParity_q, cfgFwft_q;
  logic [1:0] cfgInW_q, cfgOutW_q, strapInW, strapOutW;
  logic [2:0] strapSel;
  assign strapSel = {pinF_q[fcs_pkg::P_LOAD], pinF_q[fcs_pkg::P_OFFSET_DEFAULT_SEL1], pinF_q[fcs_pkg::P_OFFSET_DEFAULT_SEL0]};
  assign strapInW = !pinF_q[fcs_pkg::P_BM] ? fcs_pkg::W36 :
                    !pinF_q[fcs_pkg::P_IW] ? fcs_pkg::W36 :
                    pinF_q[fcs_pkg::P_OW] ? fcs_pkg::W9 : fcs_pkg::W18;
  assign strapOutW = !pinF_q[fcs_pkg::P_BM] ? fcs_pkg::W36 :
                     pinF_q[fcs_pkg::P_IW] ? fcs_pkg::W36 :
                     pinF_q[fcs_pkg::P_OW] ? fcs_pkg::W9 : fcs_pkg::W18;

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cfgEcho_q <= 1'b0;
      cfgSys_q <= 1'b0;
      cfgParallel_q <= 1'b0;
      cfgBig_q <= 1'b0;
      cfgSyncFlags_q <= 1'b0;
      cfgParity_q <= 1'b0;
      cfgFwft_q <= 1'b0;
      cfgInW_q <= fcs_pkg::W36;
      cfgOutW_q <= fcs_pkg::W36;
    end
    else if (mrsAct)
    begin
      cfgEcho_q <= pinF_q[fcs_pkg::P_RDHSTL];
      cfgSys_q <= pinF_q[fcs_pkg::P_SYSHSTL];
      cfgParallel_q <= pinF_q[fcs_pkg::P_LOAD];
      cfgBig_q <= ~pinF_q[fcs_pkg::P_BYTEORD];
      cfgSyncFlags_q <= pinF_q[fcs_pkg::P_FTIME];
      cfgParity_q <= pinF_q[fcs_pkg::P_PARITY];
      cfgFwft_q <= pinF_q[fcs_pkg::P_FALL_THROUGH_MODE];
      cfgInW_q <= strapInW;
      cfgOutW_q <= strapOutW;
    end
  end
  assign readPortHstl = cfgEcho_q;
  assign systemHstl = cfgSys_q;

  // ****************************************
  // Segment helpers
  // ****************************************
  function automatic logic [1:0] seg_max(input logic [1:0] w);
    return (w == fcs_pkg::W18) ? 2'h1 : (w == fcs_pkg::W9) ? 2'h3 : 2'h0;
  endfunction

  function automatic logic [1:0] seg_pos(input logic [1:0] idx, input logic [1:0] w, input logic big);
    return big ? (seg_max(w) - idx) : idx;
  endfunction

  function automatic logic [35:0] get_seg(input logic [35:0] word, input logic [1:0] idx,
                                          input logic [1:0] w, input logic big);
    logic [1:0] pos;
    pos = seg_pos(idx, w, big);
    get_seg = word;
    if (w == fcs_pkg::W18)
      get_seg = {18'h0_0000, word[pos[0]*18 +: 18]};
    else if (w == fcs_pkg::W9)
      get_seg = {27'h000_0000, word[pos*9 +: 9]};
  endfunction

  function automatic logic [35:0] put_seg(input logic [35:0] word, input logic [35:0] d,
                                          input logic [1:0] idx, input logic [1:0] w, input logic big);
    logic [1:0] pos;
    pos = seg_pos(idx, w, big);
    put_seg = word;
    if (w == fcs_pkg::W36)
      put_seg = d;
    else if (w == fcs_pkg::W18)
      put_seg[pos[0]*18 +: 18] = d[17:0];
    else
      put_seg[pos*9 +: 9] = d[8:0];
  endfunction

  // ****************************************
  // Pointers and occupancy
  // ****************************************
  logic [35:0] mem [fcs_pkg::DEPTH_CNT];
  logic [fcs_pkg::PTR_W-1:0] wPtr_q, rPtr_q, markPtr_q, fullBase, memCount, fullCount;
  logic markAct_q, orValid_q, ef1_q, ef2_q, ne1_q, ne2_q, full1_q, full2_q;
  logic [1:0] wSeg_q, rSeg_q;
  logic [35:0] asm_q, asmWord;
  logic memFull, memNonEmpty, fwftOcc, clrPtr;
  logic [11:0] occ;

  assign fullBase = markAct_q ? markPtr_q : rPtr_q;
  assign memCount = wPtr_q - rPtr_q;
  assign fullCount = wPtr_q - fullBase;
  assign memFull = {1'b0, fullCount} == fcs_pkg::DEPTH_CNT;
  assign memNonEmpty = memCount != '0;
  assign fwftOcc = cfgFwft_q & orValid_q;
  assign occ = {1'b0, memCount} + {11'h000, fwftOcc};
  assign clrPtr = mrsAct | prsAct;

  // ****************************************
  // Write side
  // ****************************************
  logic wrStrobe, fifoWr, push, ofsWr;
  assign wrStrobe = wRise & ~pinF_q[fcs_pkg::P_WEN] & ~clrPtr;
  assign fifoWr = wrStrobe & ldHigh & ~memFull;
  assign push = fifoWr & (wSeg_q == seg_max(cfgInW_q));
  assign asmWord = put_seg(asm_q, dIn, wSeg_q, cfgInW_q, cfgBig_q);
  assign ofsWr = wrStrobe & ~ldHigh & cfgParallel_q;

  always_ff @(posedge sys_clk)
  begin
    if (push)
      mem[wPtr_q[fcs_pkg::AW-1:0]] <= asmWord;
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      wPtr_q <= '0;
      wSeg_q <= fcs_pkg::SEG_RESET;
      asm_q <= 36'h0_0000_0000;
    end
    else if (clrPtr)
    begin
      wPtr_q <= '0;
      wSeg_q <= fcs_pkg::SEG_RESET;
    end
    else if (fifoWr)
    begin
      asm_q <= asmWord;
      wSeg_q <= push ? fcs_pkg::SEG_RESET : wSeg_q + 2'h1;
      if (push)
        wPtr_q <= wPtr_q + 11'h001;
    end
  end

  // ****************************************
  // Read side
  // ****************************************
  logic rdStrobe, rdStd, fwftLoad, fwftDrop, load, popWord, ofsRd, lastPop;
  logic [35:0] headSeg;
  assign rdStrobe = rRise & ~pinF_q[fcs_pkg::P_REN] & ~clrPtr;
  assign rdStd = ~cfgFwft_q & rdStrobe & ldHigh & ef2_q & memNonEmpty;
  assign fwftLoad = cfgFwft_q & rRise & ~clrPtr & ldHigh & ne2_q & memNonEmpty &
                    (~orValid_q | (rdStrobe & ldHigh));
  assign fwftDrop = cfgFwft_q & rdStrobe & ldHigh & orValid_q & ~fwftLoad;
  assign load = rdStd | fwftLoad;
  assign popWord = load & (rSeg_q == seg_max(cfgOutW_q));
  assign lastPop = popWord & ~push & (memCount == 11'h001);
  assign headSeg = get_seg(mem[rPtr_q[fcs_pkg::AW-1:0]], rSeg_q, cfgOutW_q, cfgBig_q);
  assign ofsRd = rdStrobe & ~ldHigh;

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rPtr_q <= '0;
      rSeg_q <= fcs_pkg::SEG_RESET;
      orValid_q <= 1'b0;
      ne1_q <= 1'b0;
      ne2_q <= 1'b0;
      ef1_q <= 1'b0;
      ef2_q <= 1'b0;
    end
    else if (clrPtr)
    begin
      rPtr_q <= '0;
      rSeg_q <= fcs_pkg::SEG_RESET;
      orValid_q <= 1'b0;
      ne1_q <= 1'b0;
      ne2_q <= 1'b0;
      ef1_q <= 1'b0;
      ef2_q <= 1'b0;
    end
    else if (rRise)
    begin
      ne1_q <= memNonEmpty;
      ne2_q <= ne1_q & memNonEmpty;
      ef1_q <= memNonEmpty & ~lastPop;
      ef2_q <= ef1_q & memNonEmpty & ~lastPop;
      if (load)
      begin
        rSeg_q <= popWord ? fcs_pkg::SEG_RESET : rSeg_q + 2'h1;
        if (popWord)
          rPtr_q <= rPtr_q + 11'h001;
      end
      if (fwftLoad)
        orValid_q <= 1'b1;
      else if (fwftDrop)
        orValid_q <= 1'b0;
    end
  end

  // ****************************************
  // Retransmit mark
  // ****************************************
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      markAct_q <= 1'b0;
      markPtr_q <= '0;
    end
    else if (clrPtr)
      markAct_q <= 1'b0;
    else if (rRise & ~pinF_q[fcs_pkg::P_MARK] & ldHigh)
    begin
      markAct_q <= 1'b1;
      markPtr_q <= rPtr_q;
    end
  end

  // ****************************************
  // Offset registers
  // ****************************************
  logic [fcs_pkg::OFS_W-1:0] emptyOfs_q, fullOfs_q, parOfs, ofsSel;
  logic ofsWrSel_q, ofsRdSel_q, serLoad;
  assign parOfs = cfgParity_q ? {dIn[10:9], dIn[7:0]} : dIn[9:0];
  assign serLoad = sRise & ~pinF_q[fcs_pkg::P_SEN] & ~ldHigh & ~cfgParallel_q & ~mrsAct;
  assign ofsSel = ofsRdSel_q ? fullOfs_q : emptyOfs_q;

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      emptyOfs_q <= fcs_pkg::def_offset(3'h0);
      fullOfs_q <= fcs_pkg::def_offset(3'h0);
      ofsWrSel_q <= 1'b0;
      ofsRdSel_q <= 1'b0;
    end
    else if (mrsAct)
    begin
      emptyOfs_q <= fcs_pkg::def_offset(strapSel);
      fullOfs_q <= fcs_pkg::def_offset(strapSel);
      ofsWrSel_q <= 1'b0;
      ofsRdSel_q <= 1'b0;
    end
    else if (ofsWr)
    begin
      ofsWrSel_q <= ~ofsWrSel_q;
      if (ofsWrSel_q)
        fullOfs_q <= parOfs;
      else
        emptyOfs_q <= parOfs;
    end
    else if (serLoad)
      {fullOfs_q, emptyOfs_q} <= {pinF_q[fcs_pkg::P_SIN], fullOfs_q, emptyOfs_q[fcs_pkg::OFS_W-1:1]};
    else if (ofsRd)
      ofsRdSel_q <= ~ofsRdSel_q;
  end

  // ****************************************
  // Data output register
  // ****************************************
  logic [35:0] ofsWord;
  assign ofsWord = cfgParity_q ? {25'h000_0000, ofsSel[9:8], 1'b0, ofsSel[7:0]} : {26'h000_0000, ofsSel};

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      dataOut <= 36'h0_0000_0000;
    else if (load)
      dataOut <= headSeg;
    else if (ofsRd)
      dataOut <= ofsWord;
  end

  // ****************************************
  // Full and ready flags
  // ****************************************
  logic fullRaw;
  assign fullRaw = cfgFwft_q ? (memFull & orValid_q) : memFull;

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      full1_q <= 1'b0;
      full2_q <= 1'b0;
    end
    else if (clrPtr)
    begin
      full1_q <= 1'b0;
      full2_q <= 1'b0;
    end
    else if (wRise)
    begin
      full1_q <= fullRaw;
      full2_q <= full1_q;
    end
  end
  assign fullN = cfgFwft_q ? full2_q : ~full2_q;
  assign emptyN = cfgFwft_q ? ~orValid_q : ef2_q;

  // ****************************************
  // Almost flags
  // ****************************************
  logic aeCond, afCond, aeN_q, afN_q;
  assign aeCond = occ <= ({2'h0, emptyOfs_q} + {11'h000, cfgFwft_q});
  assign afCond = (occ + {2'h0, fullOfs_q}) >= (fcs_pkg::DEPTH_CNT + {11'h000, cfgFwft_q});

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      aeN_q <= 1'b0;
      afN_q <= 1'b1;
    end
    else if (clrPtr)
    begin
      aeN_q <= 1'b0;
      afN_q <= 1'b1;
    end
    else if (cfgSyncFlags_q)
    begin
      if (rRise)
        aeN_q <= ~aeCond;
      if (wRise)
        afN_q <= ~afCond;
    end
    else
    begin
      if (rRise & aeCond)
        aeN_q <= 1'b0;
      else if (wRise & ~aeCond)
        aeN_q <= 1'b1;
      if (wRise & afCond)
        afN_q <= 1'b0;
      else if (rRise & ~afCond)
        afN_q <= 1'b1;
    end
  end
  assign almostEmptyN = aeN_q;
  assign almostFullN = afN_q;

  // ****************************************
  // Echo outputs
  // ****************************************
  logic echoClk_q, echoEn_q;
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      echoClk_q <= 1'b0;
      echoEn_q <= 1'b1;
    end
    else
    begin
      echoClk_q <= cfgEcho_q & pinF_q[fcs_pkg::P_RCLK];
      if (~cfgEcho_q)
        echoEn_q <= 1'b1;
      else if (rRise)
        echoEn_q <= ~(rdStd | (fwftLoad & orValid_q));
    end
  end
  assign echoedReadClk = echoClk_q;
  assign echoedReadEnN = echoEn_q;
endmodule

// ===== sim/fcs_flags_properties.sv
// Port checker for the FIFO flag block.
// Bound into fcs_flags_top; link clocks run far slower than sys_clk.
`timescale 1ns/10ps
module fcs_flags_properties (
  input wire logic sys_clk, // Clock
  input wire logic resetn, // Reset
  input wire logic masterResetN, // Pin
  input wire logic partialResetN, // Pin
  input wire logic readPortSignalSel, // Strap
  input wire logic systemSignalSel, // Strap
  input wire logic writeClk, // Pin
  input wire logic readClk, // Pin
  input wire logic [35:0] dataOut, // Data
  input wire logic fullN, // Flag
  input wire logic emptyN, // Flag
  input wire logic almostEmptyN, // Flag
  input wire logic almostFullN, // Flag
  input wire logic echoedReadClk, // Echo
  input wire logic echoedReadEnN, // Echo
  input wire logic readPortHstl, // Strap seen
  input wire logic systemHstl // Strap seen
);
  // ****************************************
  // Quiet counters
  // ****************************************
  logic [3:0] rQuiet_q, wQuiet_q, mrLow_q, mrHigh_q;
  wire rBusy = readClk || !masterResetN || !partialResetN;
  wire wBusy = writeClk || !masterResetN || !partialResetN;
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rQuiet_q <= 4'h0;
      wQuiet_q <= 4'h0;
      mrLow_q <= 4'h0;
      mrHigh_q <= 4'h0;
    end
    else
    begin
      rQuiet_q <= rBusy ? 4'h0 : rQuiet_q + {3'h0, rQuiet_q != 4'hf};
      wQuiet_q <= wBusy ? 4'h0 : wQuiet_q + {3'h0, wQuiet_q != 4'hf};
      mrLow_q <= masterResetN ? 4'h0 : mrLow_q + {3'h0, mrLow_q != 4'hf};
      mrHigh_q <= !masterResetN ? 4'h0 : mrHigh_q + {3'h0, mrHigh_q != 4'hf};
    end
  end
  default clocking dc @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  // ****************************************
  // Assertions
  // ****************************************
  a_reset_state: assert property ($rose(resetn) |-> fullN && !emptyN && almostFullN && !almostEmptyN)
    else $error("Flags wrong after reset");
  a_echo_off: assert property (!readPortHstl && !$past(readPortHstl) |-> !echoedReadClk && echoedReadEnN)
    else $error("Echo outputs active while disabled");
  a_dout_quiet: assert property (rQuiet_q >= 4'h8 |-> $stable(dataOut))
    else $error("Data out moved without read clock");
  a_empty_quiet: assert property (rQuiet_q >= 4'h8 |-> $stable(emptyN))
    else $error("Empty flag moved without read clock");
  a_full_quiet: assert property (wQuiet_q >= 4'h8 |-> $stable(fullN))
    else $error("Full flag moved without write clock");
  a_straps_held: assert property (mrHigh_q >= 4'h8 |-> $stable(readPortHstl) && $stable(systemHstl))
    else $error("Captured strap changed outside master reset");
  a_straps_taken: assert property (mrLow_q >= 4'ha |->
    readPortHstl == readPortSignalSel && systemHstl == systemSignalSel)
    else $error("Strap not captured in master reset");
  a_mr_flags: assert property (mrLow_q >= 4'h8 |-> !almostEmptyN && almostFullN)
    else $error("Almost flags wrong in master reset");
endmodule
bind fcs_flags_top fcs_flags_properties chk (.sys_clk, .resetn, .masterResetN, .partialResetN, .readPortSignalSel,
  .systemSignalSel, .writeClk, .readClk, .dataOut, .fullN, .emptyN, .almostEmptyN, .almostFullN, .echoedReadClk,
  .echoedReadEnN, .readPortHstl, .systemHstl);

// ===== sim/fcs_link_model.sv
// Writer and reader on the far side of the FIFO, one 64 ns clock per call.
// Called from the bench one transfer at a time; both clocks stand low between calls.
`timescale 1ns/10ps
module fcs_link_model (
  output logic writeClk, // Write clock
  output logic writeEnN, // Write enable
  output logic [35:0] dataIn, // Write data
  output logic readClk, // Read clock
  output logic readEnN // Read enable
);
  // ****************************************
  // Transfers
  // ****************************************
  initial
  begin
    writeClk = 1'b0;
    writeEnN = 1'b1;
    dataIn = 36'h0;
    readClk = 1'b0;
    readEnN = 1'b1;
  end
  // Released data shows the inverse so stale values never match
  task automatic wr(input logic [35:0] d, input logic enN);
    #13;
    writeEnN = enN;
    dataIn = d;
    #19;
    writeClk = 1'b1;
    #32;
    writeClk = 1'b0;
    writeEnN = 1'b1;
    dataIn = ~d;
  endtask
  task automatic rd(input logic enN);
    #13;
    readEnN = enN;
    #19;
    readClk = 1'b1;
    #32;
    readClk = 1'b0;
    readEnN = 1'b1;
  endtask
endmodule

// ===== sim/tb.sv
// Self-checking bench for the FIFO strap capture and status flags.
// Assumes fcs_link_model as writer and reader, checker bound separately.
`timescale 1ns/10ps
module tb;
  typedef struct {logic [7:0] cfg; int nw; int nr; logic [35:0] w;} fcs_row_t;
  logic sys_clk, resetn, masterResetN, partialResetN, offsetLoadN, readPortSignalSel, systemSignalSel;
  logic offsetDefaultSel0, offsetDefaultSel1, widthMatchEnable, inputWidthSel, outputWidthSel, byteOrderSelN;
  logic flagTimingSel, parityPlacementSel, fallThroughMode, writeClk, writeEnN, readClk, readEnN;
  logic fullN, emptyN, almostEmptyN, almostFullN, echoedReadClk, echoedReadEnN, readPortHstl, systemHstl;
  logic [35:0] dataIn, dataOut;
  logic markN, serialClk, serialEnN, serialIn;
  int nErrors = 0;
  int compares = 0;
  int cycles = 0;
  // Config bits: echo, fall-through, match, in, out, byte order, offset selects
  fcs_row_t rows [9] = '{'{8'h81, 1, 1, 36'h9_8765_4321}, '{8'h22, 1, 2, 36'ha_bcde_f012},
    '{8'ha7, 1, 2, 36'h1_2345_6789}, '{8'h28, 1, 4, 36'hf_0e1d_2c3b}, '{8'hac, 1, 4, 36'h4_5a69_7887},
    '{8'h31, 2, 1, 36'hc_3b4a_5968}, '{8'hb4, 2, 1, 36'h7_1828_3940}, '{8'h3a, 4, 1, 36'h5_0617_2839},
    '{8'hbf, 4, 1, 36'he_d0c1_b2a3}};
  fcs_flags_top dut (.sys_clk, .resetn, .masterResetN, .partialResetN, .readPortSignalSel, .systemSignalSel,
    .offsetLoadN, .offsetDefaultSel0, .offsetDefaultSel1, .widthMatchEnable, .inputWidthSel, .outputWidthSel,
    .byteOrderSelN, .flagTimingSel, .parityPlacementSel, .fallThroughMode, .writeClk, .writeEnN, .dataIn,
    .readClk, .readEnN, .markN, .serialClk, .serialEnN, .serialIn, .dataOut, .fullN,
    .emptyN, .almostEmptyN, .almostFullN, .echoedReadClk, .echoedReadEnN, .readPortHstl, .systemHstl);
  fcs_link_model lnk (.writeClk, .writeEnN, .dataIn, .readClk, .readEnN);
  // ****************************************
  // Helpers
  // ****************************************
  initial
  begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      nErrors++;
      endOfTest();
    end
  end
  // Segment k in transfer order of a word cut into n parts
  function automatic logic [35:0] seg(input logic [35:0] w, input int n, input int k, input logic beN);
    int sw;
    int idx;
    sw = 36 / n;
    idx = beN ? k : n - 1 - k;
    return (w >> (idx * sw)) & ((36'h1 << sw) - 36'h1);
  endfunction
  task automatic check(input string name, input logic [35:0] seen, input logic [35:0] exp);
    compares++;
    if (seen !== exp)
    begin
      nErrors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic mreset(input logic [7:0] c);
    @(posedge sys_clk);
    {readPortSignalSel, fallThroughMode, widthMatchEnable, inputWidthSel, outputWidthSel, byteOrderSelN,
      offsetDefaultSel1, offsetDefaultSel0} <= c;
    systemSignalSel <= ~c[0];
    flagTimingSel <= c[1];
    parityPlacementSel <= c[2];
    masterResetN <= 1'b0;
    repeat (12) @(posedge sys_clk);
    masterResetN <= 1'b1;
    repeat (8) @(posedge sys_clk);
    #1;
  endtask
  task automatic idleRd(input int n);
    repeat (n) lnk.rd(1'b1);
  endtask
  task automatic endOfTest();
    $display("Comparisons %0d, mismatches %0d", compares, nErrors);
    if (nErrors == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    resetn = 1'b0;
    masterResetN = 1'b0;
    partialResetN = 1'b1;
    offsetLoadN = 1'b1;
    {markN, serialEnN, serialClk, serialIn} = 4'hc;
    {readPortSignalSel, systemSignalSel, offsetDefaultSel0, offsetDefaultSel1, widthMatchEnable} = 5'h0;
    {inputWidthSel, outputWidthSel, byteOrderSelN, flagTimingSel, parityPlacementSel, fallThroughMode} = 6'h0;
    repeat (3) @(posedge sys_clk);
    resetn <= 1'b1;
    repeat (2) @(posedge sys_clk);
    #1;
    check("resetFlags", 36'({fullN, emptyN, almostEmptyN, almostFullN, echoedReadEnN}), 36'h13);
    foreach (rows[i])
    begin
      mreset(rows[i].cfg);
      check("emptyBefore", 36'(emptyN), 36'h0);
      for (int k = 0; k < rows[i].nw; k++)
        lnk.wr(seg(rows[i].w, rows[i].nw, k, rows[i].cfg[2]), 1'b0);
      idleRd(2);
      check("emptyAfterWrite", 36'(emptyN), 36'h1);
      for (int k = 0; k < rows[i].nr; k++)
      begin
        lnk.rd(1'b0);
        check("readSegment", dataOut, seg(rows[i].w, rows[i].nr, k, rows[i].cfg[2]));
      end
      idleRd(2);
      check("emptyAfterRead", 36'(emptyN), 36'h0);
    end
    mreset(8'h80);
    for (int i = 0; i < 1024; i++)
      lnk.wr(36'(i), 1'b0);
    lnk.wr(36'h0, 1'b1);
    lnk.wr(36'hf_ffff_ffff, 1'b0);
    check("fullAtDepth", 36'(fullN), 36'h0);
    check("almostFull", 36'(almostFullN), 36'h0);
    idleRd(2);
    lnk.rd(1'b0);
    check("firstWord", dataOut, 36'h0);
    check("fullHeld", 36'(fullN), 36'h0);
    lnk.wr(36'h0, 1'b1);
    check("fullOneEdge", 36'(fullN), 36'h0);
    lnk.wr(36'h0, 1'b1);
    check("fullCleared", 36'(fullN), 36'h1);
    for (int i = 1; i < 1024; i++)
      lnk.rd(1'b0);
    check("lastWord", dataOut, 36'h3ff);
    mreset(8'hc0);
    check("inputReady", 36'(fullN), 36'h0);
    @(posedge sys_clk) offsetLoadN <= 1'b0;
    lnk.wr(36'h5_5555_aaaa, 1'b0);
    {serialEnN, serialIn} <= 2'h1;
    repeat (4)
    begin
      repeat (8) @(posedge sys_clk);
      serialClk <= ~serialClk;
    end
    lnk.rd(1'b0);
    check("emptyOfsRead", dataOut, 36'h0_0000_02aa);
    lnk.rd(1'b0);
    check("serialRefused", dataOut, 36'h0_0000_007f);
    @(posedge sys_clk) offsetLoadN <= 1'b1;
    idleRd(4);
    check("loadBlocksData", 36'(emptyN), 36'h1);
    lnk.wr(36'h6_7890_abcd, 1'b0);
    idleRd(2);
    check("notYet", 36'({emptyN, dataOut == 36'h6_7890_abcd}), 36'h2);
    idleRd(1);
    check("fallThrough", 36'(emptyN), 36'h0);
    check("fallData", dataOut, 36'h6_7890_abcd);
    lnk.rd(1'b0);
    check("lastRead", 36'(emptyN), 36'h1);
    check("dataKept", dataOut, 36'h6_7890_abcd);
    @(posedge sys_clk) partialResetN <= 1'b0;
    fallThroughMode <= 1'b0;
    repeat (12) @(posedge sys_clk);
    partialResetN <= 1'b1;
    repeat (8) @(posedge sys_clk);
    lnk.wr(36'h3_c3c3_3c3c, 1'b0);
    idleRd(3);
    check("modeKept", dataOut, 36'h3_c3c3_3c3c);
    endOfTest();
  end
endmodule
